// *** design/sahi_regs.svh ***
`ifndef SAHI_REGS_SVH
`define SAHI_REGS_SVH

// Word and byte widths
`define SAHI_WORD_W      16
`define SAHI_BYTE_W      8
`define SAHI_SER_BITS    5'd16

// Reset values
`define SAHI_RESULT_RST  16'h0000
`define SAHI_BYTE_RST    8'h00

// Format field: two's complement flips the top bit of offset binary
`define SAHI_SIGN_FLIP   16'h8000

// Clock and timing
`define SAHI_CLK_NS      10
`define SAHI_CONV_NS     20000
`define SAHI_CONV_CYC    (`SAHI_CONV_NS / `SAHI_CLK_NS)
`define SAHI_SCLK_HALF   2'd2

`endif

// *** design/sahi_pkg.sv ***
`default_nettype none
package sahi_pkg;

   typedef enum logic [2:0] {
      SAHI_IDLE = 3'b001,
      SAHI_CONV = 3'b010,
      SAHI_DONE = 3'b100
   } sahi_state_t;

   typedef struct packed {
      logic cs_n;
      logic rd_conv;
      logic byte_sel;
      logic fmt_sb;
      logic ext_clk;
      logic analog_power_down;
      logic reference_disable;
   } sahi_pins_t;

   typedef struct packed {
      sahi_pins_t s1;
      sahi_pins_t s2;
   } sahi_sync_t;

   typedef struct packed {
      logic        rst_s1;
      logic        rst_s2;
      logic        tog_s1;
      logic        tog_s2;
      logic        tog_seen;
      logic [15:0] shreg;
   } sahi_link_t;

endpackage : sahi_pkg
`default_nettype wire

// *** design/sahi_sync.sv ***
`default_nettype none
module sahi_sync
   import sahi_pkg::*;
(
   input  wire logic       clk,
   input  wire sahi_pins_t pins_in,
   output sahi_pins_t      pins_out
);

   sahi_sync_t q;
   sahi_sync_t next_q;

   // First stage feeds only the second stage
   always_comb begin
      next_q    = q;
      next_q.s1 = pins_in;
      next_q.s2 = q.s1;
   end

   always_ff @(posedge clk) begin
      q <= next_q;
   end

   assign pins_out = q.s2;

endmodule : sahi_sync
`default_nettype wire

// *** design/sahi_link_shift.sv ***
`include "sahi_regs.svh"
`default_nettype none
module sahi_link_shift
   import sahi_pkg::*;
(
   input  wire logic                    link_clk,
   input  wire logic                    rst_n,
   input  wire logic [`SAHI_WORD_W-1:0] word,
   input  wire logic                    load_tog,
   input  wire logic                    chain_in,
   output logic                         serial_result_out
);

   sahi_link_t q;
   sahi_link_t next_q;
   logic       link_rst;

   assign link_rst = !q.rst_s2;

   always_comb begin
      next_q        = q;
      next_q.rst_s1 = rst_n;
      next_q.rst_s2 = q.rst_s1;
      next_q.tog_s1 = load_tog;
      next_q.tog_s2 = q.tog_s1;
      if (link_rst) begin
         next_q.tog_seen = 1'b0;
         next_q.shreg    = `SAHI_RESULT_RST;
      end else if (q.tog_s2 != q.tog_seen) begin
         // Word is static while the toggle is in flight
         next_q.tog_seen = q.tog_s2;
         next_q.shreg    = word;
      end else begin
         // Chained data follows the 16 result bits
         next_q.shreg = {q.shreg[`SAHI_WORD_W-2:0], chain_in};
      end
   end

   always_ff @(posedge link_clk) begin
      q <= next_q;
   end

   // Changes after the rising edge, host samples on falling
   assign serial_result_out = q.shreg[`SAHI_WORD_W-1];

endmodule : sahi_link_shift
`default_nettype wire

// *** design/sahi_top.sv ***
`include "sahi_regs.svh"
`default_nettype none
module sahi_top
   import sahi_pkg::*;
(
   input  wire logic                    CLK,
   input  wire logic                    RST_N,
   input  wire logic                    CS_N,
   input  wire logic                    RD_CONV,
   input  wire logic                    BYTE_SEL,
   input  wire logic                    OUTPUT_FORMAT_SELECT,
   input  wire logic                    SHIFT_CLK_EXT,
   input  wire logic                    ANALOG_POWER_DOWN,
   input  wire logic                    REFERENCE_DISABLE,
   input  wire logic [`SAHI_WORD_W-1:0] CONV_CODE,
   input  wire logic                    SERIAL_SHIFT_CLOCK_I,
   input  wire logic                    CHAIN_IN,
   output logic                         SERIAL_SHIFT_CLOCK_O,
   output logic                         SERIAL_SHIFT_CLOCK_OE,
   output logic                         SERIAL_RESULT_OUT,
   output logic [`SAHI_BYTE_W-1:0]      DATA_O,
   output logic                         DATA_OE,
   output logic                         BUSY_N,
   output logic                         SAMPLE_HOLD,
   output logic                         ANALOG_SHUTDOWN,
   output logic                         REF_SHUTDOWN
);

   typedef struct packed {
      sahi_state_t                 state;
      logic [11:0]                 conv_cnt;
      logic [1:0]                  div_cnt;
      logic [4:0]                  bit_cnt;
      logic                        shifting;
      logic                        sclk;
      logic                        serial_result_out_int;
      logic [`SAHI_WORD_W-1:0]     shreg;
      logic [`SAHI_WORD_W-1:0]     result;
      logic [`SAHI_WORD_W-1:0]     ext_word;
      logic                        ext_tog;
      logic                        strobe_prev;
      logic                        rd_prev;
      logic                        drive;
      logic [`SAHI_BYTE_W-1:0]     pbyte;
      logic                        busy_n;
      logic                        hold;
      logic                        ana_off;
      logic                        ref_off;
   } sahi_top_t;

   sahi_top_t  q;
   sahi_top_t  next_q;
   sahi_pins_t pins_raw;
   sahi_pins_t pins;
   logic       strobe;
   logic       start;
   logic       rd_rise;
   logic [`SAHI_WORD_W-1:0] coded;
   logic       serial_result_out_ext;

   assign pins_raw.cs_n     = CS_N;
   assign pins_raw.rd_conv  = RD_CONV;
   assign pins_raw.byte_sel = BYTE_SEL;
   assign pins_raw.fmt_sb   = OUTPUT_FORMAT_SELECT;
   assign pins_raw.ext_clk  = SHIFT_CLK_EXT;
   assign pins_raw.analog_power_down     = ANALOG_POWER_DOWN;
   assign pins_raw.reference_disable     = REFERENCE_DISABLE;

   sahi_sync u_sync (
      .clk      (CLK),
      .pins_in  (pins_raw),
      .pins_out (pins)
   );

   // Select and strobe merge into one low-active start
   assign strobe  = pins.cs_n | pins.rd_conv;
   assign rd_rise = !q.rd_prev && pins.rd_conv;

   // Any falling edge of the merged strobe is a request
   assign start = q.strobe_prev && !strobe;

   // Stored code is offset binary; low format flips the sign
   assign coded = pins.fmt_sb ? q.result
                              : (q.result ^ `SAHI_SIGN_FLIP);

   always_comb begin
      next_q             = q;
      next_q.strobe_prev = strobe;
      next_q.rd_prev     = pins.rd_conv;
      next_q.ana_off     = pins.analog_power_down;
      next_q.ref_off     = pins.reference_disable;

      // Parallel byte lanes
      if (pins.byte_sel) begin
         next_q.pbyte = coded[`SAHI_BYTE_W-1:0];
      end else begin
         next_q.pbyte = coded[`SAHI_WORD_W-1:`SAHI_BYTE_W];
      end

      // Drivers open while selected with strobe high, close on deselect or strobe low
      if (pins.cs_n || !pins.rd_conv) begin
         next_q.drive = 1'b0;
      end else if (rd_rise || !q.drive) begin
         next_q.drive = 1'b1;
      end

      // Internal serial clock divider and shifter
      if (q.shifting) begin
         if (q.div_cnt == `SAHI_SCLK_HALF - 2'd1) begin
            next_q.div_cnt = 2'd0;
            next_q.sclk    = !q.sclk;
            if (q.sclk) begin
               // Data moves on the falling edge only
               next_q.shreg     = {q.shreg[`SAHI_WORD_W-2:0], 1'b0};
               next_q.serial_result_out_int = q.shreg[`SAHI_WORD_W-2];
               next_q.bit_cnt   = q.bit_cnt + 5'd1;
               if (q.bit_cnt == `SAHI_SER_BITS - 5'd1) begin
                  next_q.shifting  = 1'b0;
                  next_q.serial_result_out_int = 1'b0;
               end
            end
         end else begin
            next_q.div_cnt = q.div_cnt + 2'd1;
         end
      end

      case (q.state)
         SAHI_IDLE: begin
            next_q.busy_n = 1'b1;
            if (start) begin
               next_q.state    = SAHI_CONV;
               next_q.busy_n   = 1'b0;
               next_q.hold     = 1'b1;
               next_q.conv_cnt = 12'(`SAHI_CONV_CYC - 1);
               if (!pins.ext_clk) begin
                  // Previous result leaves MSB first
                  next_q.shifting  = 1'b1;
                  next_q.shreg     = coded;
                  next_q.serial_result_out_int = coded[`SAHI_WORD_W-1];
                  next_q.bit_cnt   = 5'd0;
                  next_q.div_cnt   = 2'd0;
                  next_q.sclk      = 1'b0;
               end
            end
         end
         SAHI_CONV: begin
            // Further requests fall through unheeded
            if (q.conv_cnt != 12'd0) begin
               next_q.conv_cnt = q.conv_cnt - 12'd1;
            end else if (!q.shifting) begin
               next_q.result = CONV_CODE;
               next_q.hold   = 1'b0;
               next_q.state  = SAHI_DONE;
            end
         end
         SAHI_DONE: begin
            // One cycle lets pins show the new word in the same cycle busy rises
            next_q.ext_word = coded;
            // External reads only; an unread toggle pair would cancel
            if (pins.ext_clk) begin
               next_q.ext_tog = !q.ext_tog;
            end
            next_q.busy_n   = 1'b1;
            next_q.state    = SAHI_IDLE;
         end
         default: begin
            next_q.state  = SAHI_IDLE;
            next_q.busy_n = 1'b1;
         end
      endcase

      if (!RST_N) begin
         next_q.state       = SAHI_IDLE;
         next_q.conv_cnt    = 12'd0;
         next_q.div_cnt     = 2'd0;
         next_q.bit_cnt     = 5'd0;
         next_q.shifting    = 1'b0;
         next_q.sclk        = 1'b0;
         next_q.serial_result_out_int   = 1'b0;
         next_q.shreg       = `SAHI_RESULT_RST;
         next_q.result      = `SAHI_RESULT_RST;
         next_q.ext_word    = `SAHI_RESULT_RST;
         next_q.ext_tog     = 1'b0;
         next_q.strobe_prev = 1'b1;
         next_q.rd_prev     = 1'b1;
         next_q.drive       = 1'b0;
         next_q.pbyte       = `SAHI_BYTE_RST;
         next_q.busy_n      = 1'b1;
         next_q.hold        = 1'b0;
         next_q.ana_off     = 1'b0;
         next_q.ref_off     = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      q <= next_q;
   end

   sahi_link_shift u_link (
      .link_clk (SERIAL_SHIFT_CLOCK_I),
      .rst_n    (RST_N),
      .word     (q.ext_word),
      .load_tog (q.ext_tog),
      .chain_in (CHAIN_IN),
      .serial_result_out    (serial_result_out_ext)
   );

   // Pin direction follows the clock source select
   assign SERIAL_SHIFT_CLOCK_OE = !pins.ext_clk;
   assign SERIAL_SHIFT_CLOCK_O  = q.sclk;
   assign SERIAL_RESULT_OUT     = pins.ext_clk ? serial_result_out_ext
                                               : q.serial_result_out_int;
   assign DATA_O                = q.pbyte;
   assign DATA_OE               = q.drive && !pins.cs_n
                                  && pins.rd_conv;
   assign BUSY_N                = q.busy_n;
   assign SAMPLE_HOLD           = q.hold;
   assign ANALOG_SHUTDOWN       = q.ana_off;
   assign REF_SHUTDOWN          = q.ref_off;

endmodule : sahi_top
`default_nettype wire

// *** verification/sahi_assertions.sv ***
`include "sahi_regs.svh"
`default_nettype none
module sahi_assertions
   import sahi_pkg::*;
(
   input wire logic       CLK,
   input wire logic       RST_N,
   input wire logic       CS_N,
   input wire logic       RD_CONV,
   input wire logic       BYTE_SEL,
   input wire logic       OUTPUT_FORMAT_SELECT,
   input wire logic       SHIFT_CLK_EXT,
   input wire logic       ANALOG_POWER_DOWN,
   input wire logic       REFERENCE_DISABLE,
   input wire logic       SERIAL_SHIFT_CLOCK_O,
   input wire logic       SERIAL_SHIFT_CLOCK_OE,
   input wire logic       SERIAL_RESULT_OUT,
   input wire logic [7:0] DATA_O,
   input wire logic       DATA_OE,
   input wire logic       BUSY_N,
   input wire logic       SAMPLE_HOLD,
   input wire logic       ANALOG_SHUTDOWN,
   input wire logic       REF_SHUTDOWN
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int CONV = `SAHI_CONV_CYC;
   logic [15:0] busy_cnt;
   logic [4:0]  pulses;
   logic        sclk_q;
   logic [7:0]  ctl_h;
   logic        sel;
   logic        steady;
   assign sel    = !CS_N && RD_CONV;
   assign steady = ctl_h == {4{BYTE_SEL, OUTPUT_FORMAT_SELECT}};
   // Counters clear while idle, so one conversion is measured at a time
   always_ff @(posedge CLK) begin
      sclk_q   <= SERIAL_SHIFT_CLOCK_O;
      ctl_h    <= {ctl_h[5:0], BYTE_SEL, OUTPUT_FORMAT_SELECT};
      busy_cnt <= BUSY_N ? 16'h0000 : busy_cnt + 16'h0001;
      pulses   <= BUSY_N ? 5'h00 :
                  pulses + 5'(SERIAL_SHIFT_CLOCK_O && !sclk_q);
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   sequence s_start;
      $fell(CS_N | RD_CONV) && BUSY_N;
   endsequence
   sequence s_pulse;
      SERIAL_SHIFT_CLOCK_O [*2] ##1 !SERIAL_SHIFT_CLOCK_O;
   endsequence
   a_start_busy: assert property (s_start |-> ##[2:5] !BUSY_N)
      else $error("busy did not fall after start");
   a_busy_length: assert property ($rose(BUSY_N) |->
      busy_cnt >= CONV && busy_cnt <= CONV + 8)
      else $error("busy length wrong");
   a_result_hold: assert property (
      SAMPLE_HOLD && steady |-> $stable(DATA_O))
      else $error("result changed while converting");
   a_bus_float: assert property (DATA_OE |-> $past(sel, 2))
      else $error("data bus driven while deselected");
   a_bus_drive: assert property (
      $past(sel, 3) && $past(sel, 2) |-> DATA_OE)
      else $error("data bus not driven");
   a_clk_dir: assert property (
      SERIAL_SHIFT_CLOCK_OE == !$past(SHIFT_CLK_EXT, 2))
      else $error("shift clock direction wrong");
   a_pulse_shape: assert property (
      $rose(SERIAL_SHIFT_CLOCK_O) |-> s_pulse)
      else $error("shift clock pulse shape wrong");
   a_pulse_count: assert property (
      $rose(BUSY_N) && SERIAL_SHIFT_CLOCK_OE |-> pulses == 5'h10)
      else $error("shift pulse count wrong");
   a_serial_result_out_step: assert property (
      SERIAL_SHIFT_CLOCK_OE && $stable(SERIAL_SHIFT_CLOCK_OE) &&
      $changed(SERIAL_RESULT_OUT) |->
      $fell(SERIAL_SHIFT_CLOCK_O) || $fell(BUSY_N))
      else $error("serial data moved off clock fall");
   a_shutdown: assert property (
      {ANALOG_SHUTDOWN, REF_SHUTDOWN} ==
      $past({ANALOG_POWER_DOWN, REFERENCE_DISABLE}, 3))
      else $error("shutdown outputs wrong");
endmodule : sahi_assertions
bind sahi_top sahi_assertions u_sahi_assertions (.*);
`default_nettype wire

// *** verification/sahi_host_model.sv ***
`default_nettype none
module sahi_host_model
   import sahi_pkg::*;
(
   input  wire logic   serial_result_out,
   output logic        sclk,
   output logic        chain,
   output logic [17:0] word
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sclk  = 1'b0;
      chain = 1'b0;
      word  = 18'h0_0000;
   end
   // Clock stands low between frames; first two rises only flush
   task automatic frame(input int n);
      #7;
      for (int i = 0; i < n; i++) begin
         #15 sclk = 1'b1;
         #15 sclk = 1'b0;
         chain = ~chain;
         if (i >= 2)
            word = {word[16:0], serial_result_out};
      end
   endtask : frame
endmodule : sahi_host_model
`default_nettype wire

// *** verification/tb.sv ***
`default_nettype none
module tb
   import sahi_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic CLK, RST_N, CS_N, RD_CONV, BYTE_SEL, OUTPUT_FORMAT_SELECT;
   logic SHIFT_CLK_EXT, ANALOG_POWER_DOWN, REFERENCE_DISABLE, host_clk;
   logic SERIAL_SHIFT_CLOCK_I, CHAIN_IN, SERIAL_SHIFT_CLOCK_O, DATA_OE;
   logic SERIAL_SHIFT_CLOCK_OE, SERIAL_RESULT_OUT, BUSY_N, SAMPLE_HOLD;
   logic ANALOG_SHUTDOWN, REF_SHUTDOWN;
   logic [15:0] CONV_CODE, ser_q;
   logic [17:0] host_word;
   logic [7:0]  DATA_O;
   int          fail_count, total_checks, cycles;
   sahi_top u_sahi_top (.*);
   sahi_host_model u_sahi_host_model (
      .serial_result_out (SERIAL_RESULT_OUT),
      .sclk  (host_clk),
      .chain (CHAIN_IN),
      .word  (host_word)
   );
   assign SERIAL_SHIFT_CLOCK_I = SERIAL_SHIFT_CLOCK_OE ?
                                 SERIAL_SHIFT_CLOCK_O : host_clk;
   always #5 CLK = ~CLK;
   always @(posedge SERIAL_SHIFT_CLOCK_O)
      ser_q <= {ser_q[14:0], SERIAL_RESULT_OUT};
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic conclude();
      if (fail_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   task automatic cyc(int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask : cyc
   // Strobe held 5 cycles so the two-flop sync cannot miss it
   task automatic start(logic [15:0] code, logic by_cs);
      CONV_CODE = code;
      if (by_cs)
         RD_CONV = 1'b0;
      else
         CS_N = 1'b0;
      cyc(2);
      CS_N    = 1'b0;
      RD_CONV = 1'b0;
      cyc(5);
      check("oe in convert", DATA_OE, 0);
      check("hold in convert", SAMPLE_HOLD, 1);
      check("busy at start", BUSY_N, 0);
      RD_CONV = 1'b1;
   endtask : start
   task automatic wait_done();
      int n;
      for (n = 0; BUSY_N !== 1'b1 && n < 3000; n++)
         cyc(1);
      check("conversion ends", n < 3000, 1);
      check("hold released", SAMPLE_HOLD, 0);
   endtask : wait_done
   task automatic read_word(logic fmt, logic [15:0] exp);
      OUTPUT_FORMAT_SELECT = fmt;
      CS_N     = 1'b0;
      RD_CONV  = 1'b1;
      BYTE_SEL = 1'b0;
      cyc(5);
      check("oe on read", DATA_OE, 1);
      check("high byte", DATA_O, exp[15:8]);
      BYTE_SEL = 1'b1;
      cyc(5);
      check("low byte", DATA_O, exp[7:0]);
   endtask : read_word
   task automatic t_power_parallel();
      ANALOG_POWER_DOWN = 1'b1;
      cyc(5);
      check("pd out", {ANALOG_SHUTDOWN, REF_SHUTDOWN}, 2'b10);
      start(16'h1234, 1'b0);
      wait_done();
      ANALOG_POWER_DOWN = 1'b0;
      REFERENCE_DISABLE = 1'b1;
      read_word(1'b1, 16'h1234);
      read_word(1'b0, 16'h9234);
      check("ref out", {ANALOG_SHUTDOWN, REF_SHUTDOWN}, 2'b01);
      REFERENCE_DISABLE = 1'b0;
      OUTPUT_FORMAT_SELECT = 1'b1;
      CS_N = 1'b1;
      cyc(5);
      check("oe deselected", DATA_OE, 0);
   endtask : t_power_parallel
   task automatic t_serial_ignore();
      start(16'hA5C3, 1'b1);
      wait_done();
      check("internal serial", ser_q, 16'h1234);
      start(16'h0F81, 1'b0);
      read_word(1'b1, 16'hA5C3);
      RD_CONV = 1'b0;
      cyc(5);
      RD_CONV = 1'b1;
      wait_done();
      cyc(10);
      check("request ignored", BUSY_N, 1);
      read_word(1'b1, 16'h0F81);
      check("serial prev", ser_q, 16'hA5C3);
   endtask : t_serial_ignore
   task automatic t_external();
      SHIFT_CLK_EXT = 1'b1;
      OUTPUT_FORMAT_SELECT = 1'b0;
      cyc(4);
      check("clock input", SERIAL_SHIFT_CLOCK_OE, 0);
      start(16'h7E19, 1'b0);
      wait_done();
      u_sahi_host_model.frame(20);
      check("external serial", host_word[17:2], 16'hFE19);
      check("chained data", host_word[1:0], 2'b10);
      cyc(1);
      SHIFT_CLK_EXT = 1'b0;
      cyc(4);
      check("clock output", SERIAL_SHIFT_CLOCK_OE, 1);
   endtask : t_external
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end
   initial begin
      {CLK, RST_N, BYTE_SEL, ANALOG_POWER_DOWN, REFERENCE_DISABLE} = 5'h00;
      {CS_N, RD_CONV, OUTPUT_FORMAT_SELECT, SHIFT_CLK_EXT} = 4'hF;
      CONV_CODE    = 16'h0000;
      fail_count   = 0;
      total_checks = 0;
      cycles       = 0;
      // Link domain needs edges while reset is held
      u_sahi_host_model.frame(4);
      cyc(1);
      RST_N = 1'b1;
      SHIFT_CLK_EXT = 1'b0;
      cyc(4);
      t_power_parallel();
      t_serial_ignore();
      t_external();
      conclude();
   end
endmodule : tb
`default_nettype wire
